// ===== bench/ewsg_mem_model.sv
// Partner model: external memory that counts strobed byte writes per lane
`timescale 1ns/1ps
module ewsg_mem_model (
   // Strobe pins seen by the memory
   input wire logic write_strobe_n,
   input wire logic high_strobe_n
);
   int low_writes  = 0;
   int high_writes = 0;

   // A strobe held low over several cycles is one write, so count falling edges only
   always @(negedge write_strobe_n) begin
      low_writes++;
   end
   always @(negedge high_strobe_n) begin
      high_writes++;
   end
endmodule

// ===== bench/ewsg_top_test.sv
// Testbench for the external write strobe generator
`timescale 1ns/1ps
module ewsg_top_test;
   import ewsg_pkg::*;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH %s exp %0d got %0d", n, e, g); end end
   logic       ref_clk = 1'b0;
   logic       rst     = 1'b1;
   logic       sel     = STROBE_SEL_COMBINED;
   logic       cyc     = 1'b0;
   logic       wr      = 1'b0;
   logic       b16     = 1'b0;
   logic       ph      = 1'b0;
   logic [1:0] be      = LANES_NONE;
   logic       wsn;
   logic       hsn;
   logic       bhen;
   int         errors    = 0;
   int         cmp_count = 0;
   int         low0;
   int         high0;

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   ewsg_top dut (.ref_clk(ref_clk), .rst(rst), .strobe_select_bit(sel), .ext_cycle(cyc),
      .ext_write(wr), .bus_16bit(b16), .byte_en(be), .strobe_phase(ph),
      .write_strobe_n(wsn), .high_strobe_n(hsn), .byte_high_enable_n(bhen));
   ewsg_mem_model mem (.write_strobe_n(wsn), .high_strobe_n(hsn));

   // Counts, verdict and end of run
   task stop_test;
      $display("Comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Inputs change only at the falling edge
   task set(input logic s, c, w, b, input logic [1:0] e);
      sel = s;
      cyc = c;
      wr  = w;
      b16 = b;
      be  = e;
      ph  = c;
   endtask

   // Pins one cycle after a qualified cycle, worked out from the scheme
   task check(input logic s, c, w, b, input logic [1:0] e);
      logic [1:0] ln;
      logic       q;
      ln = b ? e : ((e != LANES_NONE) ? LANES_BOTH : LANES_NONE);
      q  = c & w;
      if (s) begin
         `CHK("write_strobe_n", !(q && e != LANES_NONE), wsn)
         `CHK("high_strobe_n", 1'b1, hsn)
         `CHK("byte_high_enable_n", !(c && b && e[1]), bhen)
      end else begin
         `CHK("write_strobe_n", !(q && ln[0]), wsn)
         `CHK("high_strobe_n", !(q && ln[1]), hsn)
         `CHK("byte_high_enable_n", 1'b1, bhen)
      end
   endtask

   task idle_high;
      `CHK("idle pins", 3'h7, {wsn, hsn, bhen})
   endtask

   // One cycle, then idle; strobes must be released one cycle later
   task t_one(input logic s, c, w, b, input logic [1:0] e);
      @(negedge ref_clk) set(s, c, w, b, e);
      @(negedge ref_clk) check(s, c, w, b, e);
      set(s, 1'b0, 1'b0, 1'b0, LANES_NONE);
      @(negedge ref_clk) idle_high();
   endtask

   // Pins stay high throughout reset
   task t_reset;
      repeat (8) @(negedge ref_clk) idle_high();
      rst = 1'b0;
      @(negedge ref_clk) idle_high();
   endtask

   // Every mix of cycle kind, width and lanes in one scheme
   task t_sweep(input logic s);
      for (int i = 0; i < 32; i++) begin
         t_one(s, i[4], i[3], i[2], i[1:0]);
      end
   endtask

   // A word write held three cycles is one strobe per lane
   task t_hold;
      low0  = mem.low_writes;
      high0 = mem.high_writes;
      @(negedge ref_clk) set(STROBE_SEL_SPLIT, 1'b1, 1'b1, BUS_WIDTH_16, LANES_BOTH);
      repeat (3) @(negedge ref_clk) check(STROBE_SEL_SPLIT, 1'b1, 1'b1, 1'b1, LANES_BOTH);
      set(STROBE_SEL_SPLIT, 1'b0, 1'b0, 1'b0, LANES_NONE);
      @(negedge ref_clk) idle_high();
      `CHK("low writes seen", low0 + 1, mem.low_writes)
      `CHK("high writes seen", high0 + 1, mem.high_writes)
   endtask

   // A write waits for its strobe phase; the pins must not fall early
   task t_phase;
      @(negedge ref_clk);
      sel = STROBE_SEL_SPLIT;
      cyc = 1'b1;
      wr  = 1'b1;
      b16 = BUS_WIDTH_16;
      be  = LANES_BOTH;
      ph  = 1'b0;
      repeat (2) @(negedge ref_clk) idle_high();
      ph = 1'b1;
      @(negedge ref_clk) check(STROBE_SEL_SPLIT, 1'b1, 1'b1, 1'b1, LANES_BOTH);
      set(STROBE_SEL_SPLIT, 1'b0, 1'b0, 1'b0, LANES_NONE);
      @(negedge ref_clk) idle_high();
   endtask

   // Select flipped mid-write: roles hold until idle, so a strobe is never cut short
   task t_role;
      @(negedge ref_clk) set(STROBE_SEL_SPLIT, 1'b1, 1'b1, BUS_WIDTH_16, LANES_BOTH);
      @(negedge ref_clk) check(STROBE_SEL_SPLIT, 1'b1, 1'b1, 1'b1, LANES_BOTH);
      sel = STROBE_SEL_COMBINED;
      repeat (2) @(negedge ref_clk) check(STROBE_SEL_SPLIT, 1'b1, 1'b1, 1'b1, LANES_BOTH);
      set(STROBE_SEL_COMBINED, 1'b0, 1'b0, 1'b0, LANES_NONE);
      @(negedge ref_clk) idle_high();
      t_one(STROBE_SEL_COMBINED, 1'b1, 1'b1, BUS_WIDTH_16, LANES_BOTH);
   endtask

   // Reset in the middle of a write releases every strobe and the block restarts cleanly
   task t_midreset;
      @(negedge ref_clk) set(STROBE_SEL_SPLIT, 1'b1, 1'b1, BUS_WIDTH_8, 2'h1);
      @(negedge ref_clk) check(STROBE_SEL_SPLIT, 1'b1, 1'b1, 1'b0, 2'h1);
      rst = 1'b1;
      repeat (2) @(negedge ref_clk) idle_high();
      set(STROBE_SEL_SPLIT, 1'b0, 1'b0, 1'b0, LANES_NONE);
      @(negedge ref_clk) idle_high();
      rst = 1'b0;
      @(negedge ref_clk) idle_high();
      t_one(STROBE_SEL_SPLIT, 1'b1, 1'b1, BUS_WIDTH_8, 2'h2);
   endtask

   initial begin
      t_reset();
      t_sweep(STROBE_SEL_COMBINED);
      t_sweep(STROBE_SEL_SPLIT);
      t_hold();
      t_phase();
      t_role();
      t_midreset();
      t_one(STROBE_SEL_COMBINED, 1'b1, 1'b1, BUS_WIDTH_8, LANES_BOTH);
      stop_test();
   end
endmodule

// ===== rtl/ewsg_lane_sel.sv
// Byte-lane selection for one external write cycle
`timescale 1ns/1ps
module ewsg_lane_sel (
   // Cycle description
   input  wire logic                           bus_16bit,
   input  wire logic [ewsg_pkg::NUM_LANES-1:0] byte_en,
   // Lanes to strobe
   output logic      [ewsg_pkg::NUM_LANES-1:0] lanes
);
   import ewsg_pkg::*;

   // Narrow bus strobes both lanes whatever the byte address
   genvar g;
   generate
      for (g = 0; g < NUM_LANES; g++) begin : g_lane
         assign lanes[g] = (bus_16bit == BUS_WIDTH_8) ? (|byte_en) : byte_en[g];
      end
   endgenerate
endmodule

// ===== rtl/ewsg_pkg.sv
// Package with constants and types for the external write strobe generator
package ewsg_pkg;
   // ------------------------------------------------------------
   // Strobe scheme selection
   // ------------------------------------------------------------
   localparam logic STROBE_SEL_COMBINED = 1'b1;
   localparam logic STROBE_SEL_SPLIT    = 1'b0;
   localparam logic STROBE_SEL_RESET    = 1'b1;

   // ------------------------------------------------------------
   // Bus width and byte lanes
   // ------------------------------------------------------------
   localparam logic BUS_WIDTH_8  = 1'b0;
   localparam logic BUS_WIDTH_16 = 1'b1;
   localparam int   LANE_LOW     = 0;
   localparam int   LANE_HIGH    = 1;
   localparam int   NUM_LANES    = 2;
   localparam logic [1:0] LANES_NONE = 2'h0;
   localparam logic [1:0] LANES_BOTH = 2'h3;

   // ------------------------------------------------------------
   // Pin levels after reset
   // ------------------------------------------------------------
   localparam logic STROBE_IDLE = 1'b1;

   // Cycle phase of the strobe generator
   typedef enum logic [1:0] {
      EWSG_IDLE  = 2'b01,
      EWSG_WRITE = 2'b10
   } ewsg_state_t;
endpackage

// ===== rtl/ewsg_top.sv
// Top of the external write strobe generator
// Operation
// - Shared write pin: combined strobe when strobe select is one, else the low-byte strobe.
// - Second shared pin: byte high enable when strobe select is one, else the high-byte strobe.
// - The combined strobe is active low and asserted only during external memory writes.
// - On 16-bit cycles the high-byte strobe asserts for high-byte and word writes only.
// - On 16-bit cycles the low-byte strobe asserts for low-byte and word writes only.
// - On 8-bit cycles both byte strobes assert for every external write that enables at least one byte.
`timescale 1ns/1ps
module ewsg_top (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // Configuration
   input  wire logic       strobe_select_bit,
   // Bus cycle from the sequencer
   input  wire logic       ext_cycle,
   input  wire logic       ext_write,
   input  wire logic       bus_16bit,
   input  wire logic [1:0] byte_en,
   input  wire logic       strobe_phase,
   // Pins
   output logic            write_strobe_n,
   output logic            high_strobe_n,
   output logic            byte_high_enable_n
);
   import ewsg_pkg::*;

   // ------------------------------------------------------------
   // Write qualification
   // ------------------------------------------------------------
   logic [NUM_LANES-1:0] lanes;
   logic                 wr_active;
   logic                 sel_q;
   ewsg_state_t          state_q;

   // Reads, internal accesses and cycles outside the strobe phase all leave write_strobe_n and high_strobe_n high
   // external write only
   assign wr_active = ext_cycle & ext_write & strobe_phase;

   ewsg_lane_sel u_lane (
      .bus_16bit (bus_16bit),
      .byte_en   (byte_en),
      .lanes     (lanes)
   );

   // Config is sampled only between writes so a pin never changes role mid-strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sel_q <= STROBE_SEL_RESET;
      end else if (state_q == EWSG_IDLE) begin
         sel_q <= strobe_select_bit;
      end
   end

   // Phase tracker
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= EWSG_IDLE;
      end else begin
         unique case (state_q)
            EWSG_IDLE: begin
               if (wr_active) begin
                  state_q <= EWSG_WRITE;
               end
            end
            EWSG_WRITE: begin
               if (!wr_active) begin
                  state_q <= EWSG_IDLE;
               end
            end
            default: begin
               state_q <= EWSG_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pin drivers, registered so the pins are glitch free
   // ------------------------------------------------------------
   // Live select while idle, latched select once a write has begun
   logic cur_sel;
   assign cur_sel = (state_q == EWSG_IDLE) ? strobe_select_bit : sel_q;

   // A pin unused by the current scheme is parked high, so a role swap never glitches low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         write_strobe_n     <= STROBE_IDLE;
         high_strobe_n      <= STROBE_IDLE;
         byte_high_enable_n <= STROBE_IDLE;
      end else if (cur_sel == STROBE_SEL_COMBINED) begin
         write_strobe_n     <= ~(wr_active & (|byte_en));
         high_strobe_n      <= STROBE_IDLE;
         // byte high enable follows the cycle, not only writes
         byte_high_enable_n <= ~(ext_cycle & bus_16bit & byte_en[LANE_HIGH]);
      end else begin
         write_strobe_n     <= ~(wr_active & lanes[LANE_LOW]);
         high_strobe_n      <= ~(wr_active & lanes[LANE_HIGH]);
         byte_high_enable_n <= STROBE_IDLE;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // no strobe off writes
   property p_comb_only_write;
      @(posedge ref_clk) disable iff (rst)
         (!wr_active) |=> write_strobe_n;
   endproperty
   a_comb_only_write: assert property (p_comb_only_write)
      else $error("write strobe low outside a write");

   property p_split_high16;
      @(posedge ref_clk) disable iff (rst)
         (cur_sel == STROBE_SEL_SPLIT && wr_active && bus_16bit)
            |=> (high_strobe_n == !$past(byte_en[1]));
   endproperty
   a_split_high16: assert property (p_split_high16)
      else $error("high strobe wrong on 16-bit write");

   property p_split_low16;
      @(posedge ref_clk) disable iff (rst)
         (cur_sel == STROBE_SEL_SPLIT && wr_active && bus_16bit)
            |=> (write_strobe_n == !$past(byte_en[0]));
   endproperty
   a_split_low16: assert property (p_split_low16)
      else $error("low strobe wrong on 16-bit write");

   property p_split_8bit;
      @(posedge ref_clk) disable iff (rst)
         (cur_sel == STROBE_SEL_SPLIT && wr_active && !bus_16bit && byte_en != LANES_NONE)
            |=> (!write_strobe_n && !high_strobe_n);
   endproperty
   a_split_8bit: assert property (p_split_8bit)
      else $error("8-bit write missing a strobe");

   property p_comb_assert;
      @(posedge ref_clk) disable iff (rst)
         (cur_sel == STROBE_SEL_COMBINED && wr_active && byte_en != LANES_NONE)
            |=> (!write_strobe_n && high_strobe_n);
   endproperty
   a_comb_assert: assert property (p_comb_assert)
      else $error("combined strobe not asserted");

   property p_bhe_role;
      @(posedge ref_clk) disable iff (rst)
         (cur_sel == STROBE_SEL_SPLIT) |=> byte_high_enable_n;
   endproperty
   a_bhe_role: assert property (p_bhe_role)
      else $error("byte high enable active in split mode");

   property p_read_idle;
      @(posedge ref_clk) disable iff (rst)
         (ext_cycle && !ext_write) |=> (write_strobe_n && high_strobe_n);
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("strobe low during a read");

   property p_reset_idle;
      @(posedge ref_clk)
         $fell(rst) |-> (write_strobe_n && high_strobe_n && byte_high_enable_n);
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("strobe low at reset release");

   property p_high_only_write;
      @(posedge ref_clk) disable iff (rst)
         (!wr_active) |=> high_strobe_n;
   endproperty
   a_high_only_write: assert property (p_high_only_write)
      else $error("high strobe low outside a write");

   property p_no_lane_idle;
      @(posedge ref_clk) disable iff (rst)
         (wr_active && byte_en == LANES_NONE) |=> (write_strobe_n && high_strobe_n);
   endproperty
   a_no_lane_idle: assert property (p_no_lane_idle)
      else $error("strobe low with no byte addressed");

   property p_bhe_follow;
      @(posedge ref_clk) disable iff (rst)
         (cur_sel == STROBE_SEL_COMBINED)
            |=> (byte_high_enable_n == !$past(ext_cycle && bus_16bit && byte_en[LANE_HIGH]));
   endproperty
   a_bhe_follow: assert property (p_bhe_follow)
      else $error("byte high enable wrong in combined scheme");

   property p_role_held;
      @(posedge ref_clk) disable iff (rst)
         (state_q == EWSG_WRITE && wr_active && sel_q == STROBE_SEL_SPLIT)
            |=> (byte_high_enable_n && high_strobe_n == !$past(lanes[LANE_HIGH]));
   endproperty
   a_role_held: assert property (p_role_held)
      else $error("pin role changed during a write");

   // Main scenarios
   c_split_word16: cover property (@(posedge ref_clk) disable iff (rst)
      cur_sel == STROBE_SEL_SPLIT && wr_active && bus_16bit && byte_en == LANES_BOTH);
   c_split_byte8: cover property (@(posedge ref_clk) disable iff (rst)
      cur_sel == STROBE_SEL_SPLIT && wr_active && !bus_16bit && byte_en == 2'h2);
   c_comb_write: cover property (@(posedge ref_clk) disable iff (rst)
      cur_sel == STROBE_SEL_COMBINED && wr_active ##1 !wr_active);
   c_role_hold: cover property (@(posedge ref_clk) disable iff (rst)
      state_q == EWSG_WRITE && wr_active && strobe_select_bit != sel_q);
   c_phase_wait: cover property (@(posedge ref_clk) disable iff (rst)
      ext_cycle && ext_write && !strobe_phase && byte_en != LANES_NONE);
endmodule
